// file: common/swp_pkg.sv
package swp_pkg;
  localparam int WORD_BITS     = 16;
  localparam int CTRL_MSB      = 15;
  localparam int CTRL_LSB      = 12;
  localparam int ADDR_MSB      = 11;
  localparam int ADDR_LSB      = 8;
  localparam int DATA_MSB      = 7;
  localparam int DATA_LSB      = 0;
  localparam int SYNC_STAGES   = 2;
  localparam int SCLK_MAX_MHZ  = 40;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [4:0]  CNT_RST  = 5'h00;
endpackage

// file: rtl/swp_sync.sv
`timescale 1ns/1ns
module swp_sync #(
  parameter int STAGES = 2
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Level in and out
  input  wire logic d,
  output logic      q
);
  logic [STAGES-1:0] sh_r;

  initial begin
    if (STAGES < 2) $error("swp_sync needs at least two stages");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_r <= '0;
    end else begin
      sh_r <= {sh_r[STAGES-2:0], d};
    end
  end

  assign q = sh_r[STAGES-1];
endmodule

// file: rtl/swp_port.sv
`timescale 1ns/1ns
// Summary of operation
// - any clock idle level or free-running accepted
// - one low frame delivers one sixteen-bit word
// - data sampled on falling shift clock edges
// - MSB first; control, address, data fields
module swp_port #(
  parameter int WORD_W = swp_pkg::WORD_BITS,
  parameter int SYNC_N = swp_pkg::SYNC_STAGES
) (
  // System clock domain
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  // Serial link
  input  wire logic        SHIFT_CLK,
  input  wire logic        FRAME_SELECT_N,
  input  wire logic        SERIAL_DATA_IN,
  // Received word
  output logic             WORD_VALID,
  output logic [3:0]       WORD_CTRL,
  output logic [3:0]       WORD_ADDR,
  output logic [7:0]       WORD_DATA,
  output logic             WORD_DROPPED
);

  // Field layout is fixed, so only the sixteen-bit word is served
  if (WORD_W != swp_pkg::WORD_BITS) begin : g_bad_width
    $error("swp_port serves sixteen-bit words only");
  end

  if (SYNC_N < 2) begin : g_bad_sync
    $error("swp_port needs two or more synchroniser stages");
  end

  // Link domain: shift_r, cnt_r, started_r async reset by frame high so no edge after frame is needed; hold_r, done_tgl_r by SYS_RST
  logic [15:0] shift_r;
  logic [4:0]  cnt_r;
  logic [15:0] hold_r;
  logic        done_tgl_r;
  logic        started_r;

  // Falling edge sampling, frame select high clears state
  always_ff @(negedge SHIFT_CLK or posedge FRAME_SELECT_N) begin
    if (FRAME_SELECT_N) begin
      shift_r   <= swp_pkg::WORD_RST;
      cnt_r     <= swp_pkg::CNT_RST;
      started_r <= 1'b0;
    end else begin
      started_r <= 1'b1;
      if (cnt_r < 5'(swp_pkg::WORD_BITS)) begin
        shift_r <= {shift_r[14:0], SERIAL_DATA_IN};
        cnt_r   <= cnt_r + 5'h01;
      end
    end
  end

  // Complete word captured once per frame, toggle flags it
  always_ff @(negedge SHIFT_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      hold_r     <= swp_pkg::WORD_RST;
      done_tgl_r <= 1'b0;
    end else if (!FRAME_SELECT_N
                 && cnt_r == 5'(swp_pkg::WORD_BITS - 1)) begin
      hold_r     <= {shift_r[14:0], SERIAL_DATA_IN};
      done_tgl_r <= ~done_tgl_r;
    end
  end

  // Crossings into system domain, one synchroniser per level
  localparam int NCROSS = 3;

  logic [NCROSS-1:0] cross_d;
  logic [NCROSS-1:0] cross_q;
  logic              tgl_s;
  logic              frame_s;
  logic              started_s;

  assign cross_d = {started_r, ~FRAME_SELECT_N, done_tgl_r};

  for (genvar g = 0; g < NCROSS; g++) begin : g_cross
    swp_sync #(
      .STAGES (SYNC_N)
    ) u_sync (
      .clk (CLK_SYS),
      .rst (SYS_RST),
      .d   (cross_d[g]),
      .q   (cross_q[g])
    );
  end

  assign tgl_s     = cross_q[0];
  assign frame_s   = cross_q[1];
  assign started_s = cross_q[2];

  logic tgl_d_r;
  logic frame_d_r;
  logic new_word;
  logic frame_end;

  assign new_word  = tgl_s ^ tgl_d_r;
  assign frame_end = frame_d_r & ~frame_s;

  // Toggle history for word events
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      tgl_d_r <= 1'b0;
    end else begin
      tgl_d_r <= tgl_s;
    end
  end

  // Frame history for end-of-frame events
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      frame_d_r <= 1'b0;
    end else begin
      frame_d_r <= frame_s;
    end
  end

  // One-cycle strobe per delivered word
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      WORD_VALID <= 1'b0;
    end else begin
      WORD_VALID <= new_word;
    end
  end

  // Word is stable in hold_r once its toggle has crossed
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      WORD_CTRL <= 4'h0;
      WORD_ADDR <= 4'h0;
      WORD_DATA <= 8'h00;
    end else begin
      if (new_word) begin
        WORD_CTRL <= hold_r[swp_pkg::CTRL_MSB:swp_pkg::CTRL_LSB];
        WORD_ADDR <= hold_r[swp_pkg::ADDR_MSB:swp_pkg::ADDR_LSB];
        WORD_DATA <= hold_r[swp_pkg::DATA_MSB:swp_pkg::DATA_LSB];
      end
    end
  end

  // Per-frame progress seen from the system side
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_LOADED,
    ST_CLOSE
  } swp_frame_state_t;

  swp_frame_state_t frm_r;
  swp_frame_state_t frm_nxt;

  // Close state gives a late word toggle one more cycle to land
  always_comb begin
    frm_nxt = frm_r;
    case (frm_r)
      ST_IDLE: begin
        if (frame_end) begin
          frm_nxt = ST_IDLE;
        end else if (new_word) begin
          frm_nxt = ST_LOADED;
        end else if (started_s) begin
          frm_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (frame_end) begin
          frm_nxt = new_word ? ST_IDLE : ST_CLOSE;
        end else if (new_word) begin
          frm_nxt = ST_LOADED;
        end
      end
      ST_LOADED: begin
        if (frame_end) begin
          frm_nxt = ST_IDLE;
        end
      end
      ST_CLOSE: begin
        frm_nxt = ST_IDLE;
      end
      default: begin
        frm_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      frm_r <= ST_IDLE;
    end else begin
      frm_r <= frm_nxt;
    end
  end

  // Frame closed after edges but before a full word
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      WORD_DROPPED <= 1'b0;
    end else begin
      WORD_DROPPED <= (frm_r == ST_CLOSE) && !new_word;
    end
  end
endmodule

// file: test/swp_port_monitor.sv
`timescale 1ns/1ns
module swp_port_monitor (
  input wire logic       CLK_SYS, SYS_RST,
  input wire logic       SHIFT_CLK, FRAME_SELECT_N, SERIAL_DATA_IN,
  input wire logic       WORD_VALID, WORD_DROPPED,
  input wire logic [3:0] WORD_CTRL, WORD_ADDR,
  input wire logic [7:0] WORD_DATA
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  a_word_pulse: assert property (WORD_VALID |=> !WORD_VALID)
    else $error("word strobe too long");
  a_drop_pulse: assert property (WORD_DROPPED |=> !WORD_DROPPED)
    else $error("drop strobe too long");
  a_word_not_drop: assert property (WORD_VALID |-> !WORD_DROPPED)
    else $error("word and drop together");
  a_fields_on_word: assert property ($changed({WORD_CTRL, WORD_ADDR, WORD_DATA}) |-> WORD_VALID)
    else $error("fields moved without word");
  a_idle_quiet: assert property (FRAME_SELECT_N [*8] |-> !(WORD_VALID || WORD_DROPPED))
    else $error("output while frame idle");
endmodule
bind swp_port swp_port_monitor mon(.*);

// file: test/swp_host_model.sv
`timescale 1ns/1ns
module swp_host_model (
  output logic SHIFT_CLK = 1'b1,
  output logic FRAME_SELECT_N = 1'b0,
  output logic SERIAL_DATA_IN = 1'b0
);
  // Rising frame select at start clears the link shift state
  initial FRAME_SELECT_N <= 1'b1;
  task automatic send(input logic [15:0] w, input int n, input logic idl, input bit sp);
    #3 SHIFT_CLK = idl;
    #40 FRAME_SELECT_N = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      if (sp && i == 7) begin
        SHIFT_CLK = 1'b1;
        #200;
      end
      SHIFT_CLK = 1'b1;
      SERIAL_DATA_IN = w[i[3:0]];
      #40 SHIFT_CLK = 1'b0;
      #40;
    end
    SHIFT_CLK = idl;
    #40 FRAME_SELECT_N = 1'b1;
    SERIAL_DATA_IN = ~SERIAL_DATA_IN;
  endtask
endmodule

// file: test/test_swp_port.sv
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] %0t %h %h", $time, a, e); end end
module test_swp_port;
  logic        CLK_SYS = 1'b0, SYS_RST = 1'b0, WORD_VALID, WORD_DROPPED;
  wire         SHIFT_CLK, FRAME_SELECT_N, SERIAL_DATA_IN;
  logic [3:0]  WORD_CTRL, WORD_ADDR;
  logic [7:0]  WORD_DATA;
  logic [15:0] last = 16'h0000;
  int          failures = 0, samples_checked = 0, nv, nd;
  initial forever #4 CLK_SYS = ~CLK_SYS;
  swp_host_model host(.*);
  swp_port dut(.*);
  always @(posedge CLK_SYS) begin
    nv += int'(WORD_VALID === 1'b1);
    nd += int'(WORD_DROPPED === 1'b1);
  end
  task automatic print_verdict();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(logic [15:0] w, int n, logic idl, bit sp);
    nv = 0;
    nd = 0;
    host.send(w, n, idl, sp);
    repeat (12) @(posedge CLK_SYS);
    if (n >= 16) last = w;
    `CHK(nv, int'(n >= 16))
    `CHK(nd, int'(n < 16))
    `CHK({WORD_CTRL, WORD_ADDR, WORD_DATA}, last)
    $display("done %h bits %0d", w, n);
  endtask
  task automatic t_idle_low; chk(16'hA5C3, 16, 1'b0, 0); endtask
  task automatic t_split; chk(16'h3C5A, 16, 1'b1, 0); chk(16'h96E1, 16, 1'b1, 1); endtask
  task automatic t_short; chk(16'hFFFF, 9, 1'b1, 0); endtask
  task automatic t_long; chk(16'h8E71, 20, 1'b0, 0); endtask
  initial begin
    // Real rising edge so hold_r and done_tgl_r on the link side see reset too
    SYS_RST <= 1'b1;
    repeat (16) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    repeat (4) @(posedge CLK_SYS);
    t_idle_low();
    t_split();
    t_short();
    t_long();
    print_verdict();
  end
  initial begin
    #50000;
    failures++;
    print_verdict();
  end
endmodule
